// ### power_clk_pkg.sv
// Constants, register map and state encoding of the power-mode clock control
package power_clk_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned INTERNAL_SETTLE_TIME_NS = 1000;
  localparam int unsigned CPU_WAKE_DELAY_NS = 2000;
  // Least times round up to whole cycles
  localparam int unsigned SETTLE_CYCLES =
    (INTERNAL_SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_CYCLES =
    (CPU_WAKE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WDT_TIMEOUT_DEFAULT = 65536;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OSC_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] TUNE_REG_OFS = 8'h04;
  localparam logic [7:0] CONFIG_REG_OFS = 8'h08;
  localparam logic [7:0] INT_CONTROL_REG_OFS = 8'h0C;
  localparam logic [7:0] PERIPH_ENABLE_REGS_OFS = 8'h10;
  localparam logic [7:0] COMMAND_REG_OFS = 8'h14;
  localparam logic [7:0] STATUS_REG_OFS = 8'h18;
  // ==========================================================
  // Field positions
  localparam int IDLE_REQUEST_BIT = 7;
  localparam int INTERNAL_FREQ_LSB = 4;
  localparam int PRIMARY_READY_BIT = 3;
  localparam int INTERNAL_STABLE_BIT = 2;
  localparam int CLK_CHOICE_HI_BIT = 1;
  localparam int CLK_CHOICE_LO_BIT = 0;
  localparam int INT_SOURCE_SEL_BIT = 7;
  localparam int WDT_ENABLE_BIT = 4;
  localparam int FSCM_ENABLE_BIT = 5;
  localparam int GLOBAL_INT_ENABLE_BIT = 7;
  localparam int CMD_SLEEP_BIT = 0;
  localparam int CMD_WDT_CLEAR_BIT = 1;
  localparam int STATUS_STATE_LSB = 8;
  // ==========================================================
  // Reset values
  localparam logic [3:0] OSC_CHOICE_RESET = 4'h7;
  localparam logic [2:0] FREQ_RESET = 3'h0;
  // ==========================================================
  // Oscillator modes of the four-bit choice field, own codes
  localparam logic [3:0] LOW_POWER_CRYSTAL = 4'h0;
  localparam logic [3:0] CRYSTAL_MODE = 4'h1;
  localparam logic [3:0] FAST_CRYSTAL = 4'h2;
  localparam logic [3:0] FAST_XTAL_MULTIPLIED = 4'h3;
  localparam logic [3:0] RESISTOR_CAP_CLKOUT = 4'h4;
  localparam logic [3:0] RESISTOR_CAP_PINIO = 4'h5;
  localparam logic [3:0] INTERNAL_CLKOUT_MODE = 4'h6;
  localparam logic [3:0] INTERNAL_TWOIO_MODE = 4'h7;
  localparam logic [3:0] EXT_CLOCK_CLKOUT = 4'h8;
  localparam logic [3:0] EXT_CLOCK_PINIO = 4'h9;
  // ==========================================================
  // Power states, one-hot
  typedef enum logic [5:0] {
    RESET_HOLD = 6'h01,
    PRIMARY_RUN = 6'h02,
    INTERNAL_RUN_STATE = 6'h04,
    INTERNAL_IDLE_STATE = 6'h08,
    SLEEP_STATE = 6'h10,
    WAKE_WAIT = 6'h20
  } power_state_e;
endpackage

// ### power_mode_clock_ctrl.sv
// Power-mode clock control with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_ctrl #(
  parameter int unsigned WDT_TIMEOUT_CYCLES =
    power_clk_pkg::WDT_TIMEOUT_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] irq_flags,
  input wire logic primary_ok_pin,
  input wire logic clock_lost_pin,
  input wire logic gpio6_out,
  input wire logic gpio6_oe,
  input wire logic gpio7_out,
  input wire logic gpio7_oe,
  output logic porta_bit6_o,
  output logic porta_bit6_oe,
  output logic porta_bit7_o,
  output logic porta_bit7_oe,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic primary_osc_en,
  output logic internal_osc_en,
  output logic slow_osc_en,
  output logic sel_internal_mux,
  output logic cpu_resume,
  output logic branch_vector,
  output logic wdt_reset,
  output logic wdt_cleared
);
  // ==========================================================
  // State record
  typedef struct packed {
    power_clk_pkg::power_state_e state; // Power state
    logic idle_request_bit;             // Idle on sleep
    logic [2:0] internal_freq_field;    // Internal frequency
    logic clk_choice_hi;                // Upper clock select
    logic clk_choice_lo;                // Lower clock select, unused
    logic int_source_sel;               // Internal source select
    logic [3:0] osc_choice_field;       // Oscillator mode
    logic wdt_en;                       // Watchdog enable
    logic fscm_en;                      // Fail-safe monitor enable
    logic global_int_enable;            // Vector on interrupt wake
    logic [7:0] irq_en;                 // Wake enables per source
    logic primary_ready_flag;           // Primary clock ready
    logic internal_stable_flag;         // Internal output settled
    logic [7:0] settle_cnt;             // Settling counter
    logic [7:0] wake_cnt;               // Wake delay counter
    logic [19:0] wdt_cnt;               // Watchdog counter
    logic wake_by_irq;                  // Wake cause was interrupt
    logic [2:0] ok_sync;                // Primary-ok synchroniser
    logic ok_f;                         // Filtered primary ok
    logic [2:0] lost_sync;              // Clock-loss synchroniser
    logic lost_f;                       // Filtered clock loss
    logic [1:0] div;                    // Quarter-rate divider
    logic a_wr;                         // Pending write
    logic [7:0] a_addr;                 // Pending write offset
    logic [31:0] rdata;                 // Read data
    logic ready;                        // Bus ready
    logic cpu_clk_en;
    logic periph_clk_en;
    logic prim_en;
    logic int_en;
    logic slow_en;
    logic sel_int;
    logic resume;
    logic branch;
    logic wdt_rst;
    logic wdt_clr;
    logic pa6_o;
    logic pa6_oe;
    logic pa7_o;
    logic pa7_oe;
  } ctrl_s;

  ctrl_s q;
  ctrl_s d;

  // Bus and event terms seen by the next-state logic
  logic addr_ok;      // Valid word access in address phase
  logic sleep_cmd;    // Sleep instruction this cycle
  logic wdt_clr_cmd;  // Watchdog-clear instruction this cycle
  logic ctl_wr;       // Write of the oscillator control register
  logic irq_wake;     // Enabled interrupt flag raised
  logic wdt_timeout;  // Watchdog reached its limit
  logic use_internal; // Clock runs from the internal mux
  logic int_mode;     // Configured for an internal mode
  logic lost_rise;    // Selected clock just lost
  logic [31:0] rd_val; // Register read value
  logic [7:0] status_low; // Status bits 15 to 8: power state

  assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2) &&
                   (haddr[1:0] == 2'h0);
  assign sleep_cmd = q.a_wr &&
    (q.a_addr == power_clk_pkg::COMMAND_REG_OFS) &&
    hwdata[power_clk_pkg::CMD_SLEEP_BIT];
  assign wdt_clr_cmd = q.a_wr &&
    (q.a_addr == power_clk_pkg::COMMAND_REG_OFS) &&
    hwdata[power_clk_pkg::CMD_WDT_CLEAR_BIT];
  assign ctl_wr = q.a_wr &&
    (q.a_addr == power_clk_pkg::OSC_CONTROL_REG_OFS);
  assign irq_wake = |(irq_flags & q.irq_en);
  assign wdt_timeout = q.wdt_en &&
    (q.wdt_cnt == 20'(WDT_TIMEOUT_CYCLES - 1));
  assign int_mode =
    (q.osc_choice_field == power_clk_pkg::INTERNAL_CLKOUT_MODE) ||
    (q.osc_choice_field == power_clk_pkg::INTERNAL_TWOIO_MODE);
  assign use_internal = q.clk_choice_hi || int_mode;
  assign lost_rise = q.fscm_en &&
    (q.lost_sync[2] == q.lost_sync[1]) && q.lost_sync[2] && !q.lost_f;
  assign status_low = {2'h0, q.state};

  // ==========================================================
  // Register read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (haddr[7:0])
      power_clk_pkg::OSC_CONTROL_REG_OFS: begin
        rd_val[7:0] = {q.idle_request_bit, q.internal_freq_field,
                       q.primary_ready_flag, q.internal_stable_flag,
                       q.clk_choice_hi, q.clk_choice_lo};
      end
      power_clk_pkg::TUNE_REG_OFS: begin
        rd_val[power_clk_pkg::INT_SOURCE_SEL_BIT] = q.int_source_sel;
      end
      power_clk_pkg::CONFIG_REG_OFS: begin
        rd_val[5:0] = {q.fscm_en, q.wdt_en, q.osc_choice_field};
      end
      power_clk_pkg::INT_CONTROL_REG_OFS: begin
        rd_val[power_clk_pkg::GLOBAL_INT_ENABLE_BIT] =
          q.global_int_enable;
      end
      power_clk_pkg::PERIPH_ENABLE_REGS_OFS: begin
        rd_val[7:0] = q.irq_en;
      end
      power_clk_pkg::STATUS_REG_OFS: begin
        rd_val[15:0] = {status_low, irq_flags};
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    d = q;
    d.resume = 1'b0;
    d.branch = 1'b0;
    d.wdt_rst = 1'b0;
    d.wdt_clr = 1'b0;
    // Bus slave: zero wait states, always OKAY
    d.ready = 1'b1;
    d.a_wr = addr_ok && hwrite;
    d.a_addr = haddr[7:0];
    if (addr_ok && !hwrite) begin
      d.rdata = rd_val;
    end
    // Register writes in the data phase
    if (ctl_wr) begin
      d.idle_request_bit = hwdata[power_clk_pkg::IDLE_REQUEST_BIT];
      d.internal_freq_field =
        hwdata[power_clk_pkg::INTERNAL_FREQ_LSB +: 3];
      d.clk_choice_hi = hwdata[power_clk_pkg::CLK_CHOICE_HI_BIT];
      d.clk_choice_lo = hwdata[power_clk_pkg::CLK_CHOICE_LO_BIT];
    end
    if (q.a_wr && (q.a_addr == power_clk_pkg::TUNE_REG_OFS)) begin
      d.int_source_sel = hwdata[power_clk_pkg::INT_SOURCE_SEL_BIT];
    end
    if (q.a_wr && (q.a_addr == power_clk_pkg::CONFIG_REG_OFS)) begin
      d.osc_choice_field = hwdata[3:0];
      d.wdt_en = hwdata[power_clk_pkg::WDT_ENABLE_BIT];
      d.fscm_en = hwdata[power_clk_pkg::FSCM_ENABLE_BIT];
    end
    if (q.a_wr && (q.a_addr == power_clk_pkg::INT_CONTROL_REG_OFS)) begin
      d.global_int_enable = hwdata[power_clk_pkg::GLOBAL_INT_ENABLE_BIT];
    end
    if (q.a_wr && (q.a_addr == power_clk_pkg::PERIPH_ENABLE_REGS_OFS)) begin
      d.irq_en = hwdata[7:0];
    end
    // Pin synchronisers; a change counts once stages two and three agree
    d.ok_sync = {q.ok_sync[1:0], primary_ok_pin};
    d.lost_sync = {q.lost_sync[1:0], clock_lost_pin};
    if (q.ok_sync[2] == q.ok_sync[1]) begin
      d.ok_f = q.ok_sync[2];
    end
    if (q.lost_sync[2] == q.lost_sync[1]) begin
      d.lost_f = q.lost_sync[2];
    end
    d.div = q.div + 2'h1;
    // Internal output enable and settling
    d.int_en = (q.internal_freq_field != 3'h0) || q.int_source_sel;
    if (!d.int_en) begin
      d.settle_cnt = 8'h00;
      d.internal_stable_flag = 1'b0;
    end else if (q.settle_cnt != 8'(power_clk_pkg::SETTLE_CYCLES)) begin
      d.settle_cnt = q.settle_cnt + 8'h01;
    end else begin
      d.internal_stable_flag = 1'b1;
    end
    // Primary oscillator and its ready flag
    d.sel_int = use_internal;
    if (use_internal) begin
      d.primary_ready_flag = 1'b0;
    end else if (q.ok_f) begin
      d.primary_ready_flag = 1'b1;
    end
    // Watchdog counter; clear wins over counting
    if (q.wdt_en) begin
      d.wdt_cnt = wdt_timeout ? 20'h00000 : q.wdt_cnt + 20'h00001;
    end
    if (sleep_cmd || wdt_clr_cmd || lost_rise ||
        (ctl_wr && use_internal && (hwdata[6:4] != q.internal_freq_field))) begin
      d.wdt_cnt = 20'h00000;
      d.wdt_clr = 1'b1;
    end
    // Power state machine
    unique case (q.state)
      power_clk_pkg::RESET_HOLD: begin
        // Hold until the chosen clock is ready
        if ((use_internal && q.internal_stable_flag) ||
            (!use_internal && q.primary_ready_flag)) begin
          d.state = use_internal ? power_clk_pkg::INTERNAL_RUN_STATE :
                                   power_clk_pkg::PRIMARY_RUN;
        end
      end
      power_clk_pkg::PRIMARY_RUN,
      power_clk_pkg::INTERNAL_RUN_STATE: begin
        if (wdt_timeout) begin
          d.wdt_rst = 1'b1;
          d.state = power_clk_pkg::RESET_HOLD;
        end else if (sleep_cmd && q.idle_request_bit && use_internal) begin
          d.state = power_clk_pkg::INTERNAL_IDLE_STATE;
        end else if (sleep_cmd && !q.idle_request_bit) begin
          d.state = power_clk_pkg::SLEEP_STATE;
        end else begin
          d.state = use_internal ? power_clk_pkg::INTERNAL_RUN_STATE :
                                   power_clk_pkg::PRIMARY_RUN;
        end
      end
      power_clk_pkg::INTERNAL_IDLE_STATE,
      power_clk_pkg::SLEEP_STATE: begin
        // Only an enabled interrupt or a timeout leaves
        if (irq_wake || wdt_timeout) begin
          d.state = power_clk_pkg::WAKE_WAIT;
          d.wake_by_irq = irq_wake;
          d.wake_cnt = 8'h00;
        end
      end
      power_clk_pkg::WAKE_WAIT: begin
        if (q.wake_cnt == 8'(power_clk_pkg::WAKE_CYCLES - 1)) begin
          d.state = use_internal ? power_clk_pkg::INTERNAL_RUN_STATE :
                                   power_clk_pkg::PRIMARY_RUN;
          d.resume = 1'b1;
          d.branch = q.wake_by_irq && q.global_int_enable;
        end else begin
          d.wake_cnt = q.wake_cnt + 8'h01;
        end
      end
    endcase
    // Clock gates follow the next state
    d.cpu_clk_en = (d.state == power_clk_pkg::PRIMARY_RUN) ||
                   (d.state == power_clk_pkg::INTERNAL_RUN_STATE);
    d.periph_clk_en = (d.state != power_clk_pkg::SLEEP_STATE);
    d.prim_en = !use_internal && (d.state != power_clk_pkg::SLEEP_STATE);
    d.slow_en = d.wdt_en || d.fscm_en;
    // Port bits 6 and 7 by oscillator mode
    d.pa6_o = gpio6_out;
    d.pa6_oe = gpio6_oe;
    d.pa7_o = gpio7_out;
    d.pa7_oe = gpio7_oe;
    unique case (q.osc_choice_field)
      power_clk_pkg::RESISTOR_CAP_CLKOUT,
      power_clk_pkg::EXT_CLOCK_CLKOUT: begin
        d.pa6_o = q.div[1];
        d.pa6_oe = 1'b1;
        d.pa7_o = 1'b0;
        d.pa7_oe = 1'b0;
      end
      power_clk_pkg::INTERNAL_CLKOUT_MODE: begin
        d.pa6_o = q.div[1];
        d.pa6_oe = 1'b1;
      end
      power_clk_pkg::INTERNAL_TWOIO_MODE: begin
        d.pa6_oe = gpio6_oe;
      end
      power_clk_pkg::RESISTOR_CAP_PINIO,
      power_clk_pkg::EXT_CLOCK_PINIO: begin
        d.pa7_o = 1'b0;
        d.pa7_oe = 1'b0;
      end
      default: begin
        // Crystal modes and unused codes: both pins belong to the oscillator
        d.pa6_o = 1'b0;
        d.pa6_oe = 1'b0;
        d.pa7_o = 1'b0;
        d.pa7_oe = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q <= '0;
      q.state <= power_clk_pkg::RESET_HOLD;
      q.osc_choice_field <= power_clk_pkg::OSC_CHOICE_RESET;
      q.internal_freq_field <= power_clk_pkg::FREQ_RESET;
      q.ready <= 1'b1;
      q.periph_clk_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state record, hresp tied to OKAY
  assign hrdata = q.rdata;
  assign hreadyout = q.ready;
  assign hresp = 1'b0;
  assign porta_bit6_o = q.pa6_o;
  assign porta_bit6_oe = q.pa6_oe;
  assign porta_bit7_o = q.pa7_o;
  assign porta_bit7_oe = q.pa7_oe;
  assign cpu_clk_en = q.cpu_clk_en;
  assign periph_clk_en = q.periph_clk_en;
  assign primary_osc_en = q.prim_en;
  assign internal_osc_en = q.int_en;
  assign slow_osc_en = q.slow_en;
  assign sel_internal_mux = q.sel_int;
  assign cpu_resume = q.resume;
  assign branch_vector = q.branch;
  assign wdt_reset = q.wdt_rst;
  assign wdt_cleared = q.wdt_clr;

  // ==========================================================
  // Checks
  localparam int WAKE_CHK = power_clk_pkg::WAKE_CYCLES;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_idle_clock_gate: assert property (
    (q.state == power_clk_pkg::INTERNAL_IDLE_STATE) |->
      (!q.cpu_clk_en && q.periph_clk_en))
    else $error("idle state has wrong clock gates");
  chk_idle_entry: assert property (
    ((q.state == power_clk_pkg::INTERNAL_RUN_STATE) && sleep_cmd &&
     q.idle_request_bit && !wdt_timeout) |=>
      (q.state == power_clk_pkg::INTERNAL_IDLE_STATE))
    else $error("sleep with idle request missed idle");
  chk_primary_shutdown: assert property (
    q.sel_int |-> (!q.primary_ready_flag && !q.prim_en))
    else $error("primary kept while on internal mux");
  chk_int_osc_off: assert property (
    ((q.internal_freq_field == 3'h0) && !q.int_source_sel) |=>
      (!q.int_en && !q.internal_stable_flag))
    else $error("internal output on with all zero select");
  chk_settle_count: assert property (
    $rose(q.internal_stable_flag) |->
      (q.int_en && (q.settle_cnt == 8'(power_clk_pkg::SETTLE_CYCLES))))
    else $error("stable flag before settling");
  chk_stable_kept: assert property (
    (q.internal_stable_flag && q.int_en && $stable(q.internal_freq_field)
     && (q.internal_freq_field != 3'h0)) |=> q.internal_stable_flag)
    else $error("stable flag dropped while enabled");
  chk_wake_delay: assert property (
    $rose(q.state == power_clk_pkg::WAKE_WAIT) |->
      ##[WAKE_CHK:WAKE_CHK] q.resume)
    else $error("resume not after fixed wake delay");
  chk_wdt_wake: assert property (
    ((q.state == power_clk_pkg::SLEEP_STATE) && wdt_timeout) |=>
      (q.state == power_clk_pkg::WAKE_WAIT) && !q.wdt_rst)
    else $error("timeout in sleep did not wake");
  chk_wdt_reset: assert property (
    (q.cpu_clk_en && (q.state != power_clk_pkg::WAKE_WAIT) &&
     wdt_timeout) |=> q.wdt_rst)
    else $error("timeout in run gave no reset");
  chk_wdt_clear: assert property (
    (sleep_cmd || wdt_clr_cmd) |=> (q.wdt_cnt == 20'h00000))
    else $error("watchdog not cleared by instruction");
  chk_slow_osc_run: assert property (
    (q.wdt_en || q.fscm_en) |-> q.slow_en)
    else $error("slow oscillator stopped with watchdog on");
  chk_branch_gate: assert property (
    q.branch |-> $past(q.global_int_enable) && $past(q.wake_by_irq))
    else $error("vector branch without global enable");
  chk_ctl_kept: assert property (
    (q.resume && !$past(ctl_wr)) |-> $stable(q.idle_request_bit))
    else $error("wake changed idle request");

  cov_idle_wake_irq: cover property (
    (q.state == power_clk_pkg::INTERNAL_IDLE_STATE) ##1
      (q.state == power_clk_pkg::WAKE_WAIT) ##[1:60] q.branch);
  cov_sleep_wdt: cover property (
    (q.state == power_clk_pkg::SLEEP_STATE) && wdt_timeout);
  cov_run_wdt_reset: cover property (q.wdt_rst);
  cov_stable: cover property ($rose(q.internal_stable_flag));
endmodule // power_mode_clock_ctrl
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench of the power-mode clock control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // Short aliases of the register offsets
  localparam logic [7:0] OSC = power_clk_pkg::OSC_CONTROL_REG_OFS;
  localparam logic [7:0] CFG = power_clk_pkg::CONFIG_REG_OFS;
  localparam logic [7:0] STA = power_clk_pkg::STATUS_REG_OFS;
  localparam logic [7:0] CMD = power_clk_pkg::COMMAND_REG_OFS;
  // ==========================================================
  // Design inputs, all given a value at time zero
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] irq_flags = 8'h0;
  logic g6o = 1'b0;
  logic g6e = 1'b0;
  logic g7o = 1'b0;
  logic g7e = 1'b1;
  logic ok_pin = 1'b0; // Primary oscillator ready pin
  logic lost_pin = 1'b0; // Selected clock lost pin
  // Design outputs
  logic [31:0] hrdata;
  logic hreadyout, hresp, p6o, p6e, p7o, p7e, cpu_clk_en, periph_clk_en;
  logic primary_osc_en, internal_osc_en, slow_osc_en, cpu_resume;
  logic branch_vector, wdt_reset, wdt_cleared, sel_mux;
  // Verdict counters and expectation queues
  int bad_count = 0;
  int checks = 0;
  int clr_seen = 0;
  logic [31:0] rd_q[$];
  logic br_q[$];
  logic rd_ph = 1'b0;

  // Free-running 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // Watchdog shortened so that timeouts fit the run
  power_mode_clock_ctrl #(.WDT_TIMEOUT_CYCLES(64)) i_power_mode_clock_ctrl (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq_flags(irq_flags), .primary_ok_pin(ok_pin),
    .clock_lost_pin(lost_pin), .gpio6_out(g6o), .gpio6_oe(g6e),
    .gpio7_out(g7o), .gpio7_oe(g7e), .porta_bit6_o(p6o),
    .porta_bit6_oe(p6e), .porta_bit7_o(p7o), .porta_bit7_oe(p7e),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .primary_osc_en(primary_osc_en), .internal_osc_en(internal_osc_en),
    .slow_osc_en(slow_osc_en), .sel_internal_mux(sel_mux),
    .cpu_resume(cpu_resume), .branch_vector(branch_vector),
    .wdt_reset(wdt_reset), .wdt_cleared(wdt_cleared));

  // ==========================================================
  // Verdict, comparison and bus tasks
  task report_and_stop;
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for hready under a bound; a hang ends the run
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      report_and_stop;
    end
  endtask

  // One single word transfer; a read notes its expected data
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d,
           input logic [31:0] e);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) begin
      rd_q.push_back(e);
      rd_ph <= 1'b1;
    end
    wait_rdy;
    rd_ph <= 1'b0;
  endtask

  // Watcher: pops the oldest note whenever a result appears
  always @(posedge sys_clk) begin
    if (rd_ph && hreadyout === 1'b1 && rd_q.size() > 0) begin
      chk("hrdata", rd_q.pop_front(), hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    if (cpu_resume === 1'b1 && br_q.size() > 0)
      chk("branch_vector", {31'h0, br_q.pop_front()}, {31'h0, branch_vector});
    else if (cpu_resume === 1'b1)
      chk("cpu_resume", 32'h0, 32'h1);
    if (wdt_cleared === 1'b1) clr_seen++;
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] oc, ib;
    int n;
    void'($urandom(32'h7ffa));
    oc = {1'b0, 3'($urandom_range(7, 1)), 4'h2};
    ib = 8'h01 << $urandom_range(7, 0);
    g6o <= 1'($urandom);
    g7o <= 1'($urandom);
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    // Idle internal output and reset values
    chk("internal_osc_en", 32'h0, {31'h0, internal_osc_en});
    bus(CFG, 1'b0, 32'h0, 32'h07);
    bus(8'h1C, 1'b0, 32'h0, 32'h0);
    bus(OSC, 1'b0, 32'h0, 32'h0);
    // Enable internal clock, then wait out the settling time
    bus(OSC, 1'b1, {24'h0, oc}, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk("internal_osc_en", 32'h1, {31'h0, internal_osc_en});
    chk("primary_osc_en", 32'h0, {31'h0, primary_osc_en});
    chk("sel_internal_mux", 32'h1, {31'h0, sel_mux});
    repeat (power_clk_pkg::SETTLE_CYCLES + 4) @(posedge sys_clk);
    bus(OSC, 1'b0, 32'h0, {24'h0, oc | 8'h04});
    bus(STA, 1'b0, 32'h0, 32'h0400);
    // Idle entry with one random enabled source and global enable
    bus(power_clk_pkg::PERIPH_ENABLE_REGS_OFS, 1'b1, {24'h0, ib}, 32'h0);
    bus(power_clk_pkg::INT_CONTROL_REG_OFS, 1'b1, 32'h80, 32'h0);
    oc = oc | 8'h80;
    bus(OSC, 1'b1, {24'h0, oc}, 32'h0);
    bus(CMD, 1'b1, 32'h1, 32'h0);
    @(posedge sys_clk);
    #1 chk("cpu_clk_en", 32'h0, {31'h0, cpu_clk_en});
    chk("periph_clk_en", 32'h1, {31'h0, periph_clk_en});
    // Flags of disabled sources must not wake
    irq_flags <= ~ib;
    repeat (50) @(posedge sys_clk);
    chk("cpu_clk_en", 32'h0, {31'h0, cpu_clk_en});
    bus(STA, 1'b0, 32'h0, {18'h0, 6'h08, ~ib});
    @(posedge sys_clk);
    irq_flags <= 8'hFF;
    br_q.push_back(1'b1);
    repeat (power_clk_pkg::WAKE_CYCLES) @(posedge sys_clk);
    #1 chk("cpu_resume", 32'h0, {31'h0, cpu_resume});
    @(posedge sys_clk);
    #1 chk("cpu_resume", 32'h1, {31'h0, cpu_resume});
    chk("periph_clk_en", 32'h1, {31'h0, periph_clk_en});
    @(posedge sys_clk);
    irq_flags <= 8'h00;
    bus(OSC, 1'b0, 32'h0, {24'h0, oc | 8'h04});
    // Sleep with the watchdog on; its timeout wakes, then resets
    bus(power_clk_pkg::INT_CONTROL_REG_OFS, 1'b1, 32'h0, 32'h0);
    bus(CFG, 1'b1, 32'h17, 32'h0);
    #1 chk("slow_osc_en", 32'h1, {31'h0, slow_osc_en});
    oc = oc & 8'h7F;
    bus(OSC, 1'b1, {24'h0, oc}, 32'h0);
    n = clr_seen;
    bus(CMD, 1'b1, 32'h1, 32'h0);
    br_q.push_back(1'b0);
    @(posedge sys_clk);
    #1 chk("periph_clk_en", 32'h0, {31'h0, periph_clk_en});
    chk("wdt_cleared", 32'h1, {31'h0, clr_seen > n});
    n = 0;
    while (cpu_resume !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    chk("cpu_resume", 32'h1, {31'h0, cpu_resume});
    n = 0;
    while (wdt_reset !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk("wdt_reset", 32'h1, {31'h0, wdt_reset});
    // Clear command, retune and clock loss each clear the watchdog
    bus(CFG, 1'b1, 32'h37, 32'h0);
    n = clr_seen;
    bus(CMD, 1'b1, 32'h2, 32'h0);
    bus(OSC, 1'b1, {24'h0, oc ^ 8'h10}, 32'h0);
    lost_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 chk("wdt_cleared", n + 3, clr_seen);
    // Port bits 6 and 7 in the two internal modes
    bus(CFG, 1'b1, 32'h06, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk("porta_bit6_oe", 32'h1, {31'h0, p6e});
    // Quarter-rate clock on bit 6 flips every two cycles
    ib = {7'h0, p6o};
    repeat (2) @(posedge sys_clk);
    chk("porta_bit6_o", {31'h0, ~ib[0]}, {31'h0, p6o});
    chk("porta_bit7", {30'h0, g7e, g7o}, {30'h0, p7e, p7o});
    bus(CFG, 1'b1, 32'h07, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk("porta_bit6", {30'h0, g6e, g6o}, {30'h0, p6e, p6o});
    // Crystal mode on the primary clock: ready flag, pins released
    ok_pin <= 1'b1;
    bus(OSC, 1'b1, 32'h0, 32'h0);
    bus(CFG, 1'b1, 32'h02, 32'h0);
    repeat (3) @(posedge sys_clk);
    bus(OSC, 1'b0, 32'h0, 32'h08);
    chk("mux_and_primary", 32'h1, {30'h0, sel_mux, primary_osc_en});
    chk("porta_pins", 32'h0, {28'h0, p6e, p6o, p7e, p7o});
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
